// file: src/ccm_pkg.sv
package ccm_pkg;

  // register byte offsets
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_COUNT   = 8'h04;
  localparam logic [7:0]  A_PWMCFG  = 8'h08;
  localparam logic [7:0]  A_STAT    = 8'h0C;
  localparam logic [7:0]  A_CLR     = 8'h10;
  localparam logic [7:0]  A_IEN     = 8'h14;
  localparam logic [7:0]  A_CH_BASE = 8'h20;
  localparam int          CH_STRIDE = 8;
  localparam logic [7:0]  A_VAL_OFS = 8'h04;

  // module_mode_reg fields
  localparam int MB_ECCF  = 0;
  localparam int MB_PWM   = 1;
  localparam int MB_TOG   = 2;
  localparam int MB_MAT   = 3;
  localparam int MB_CAPN  = 4;
  localparam int MB_CAPP  = 5;
  localparam int MB_ECOM  = 6;
  localparam int MB_PWM16 = 7;

  // pwm_config_reg fields
  localparam int PB_CLSEL = 0;
  localparam int PB_ECOV  = 5;
  localparam int PB_ARSEL = 7;

  localparam logic [7:0]  PWM_RST  = 8'h00;
  localparam logic [15:0] LEN_BASE = 16'h0100;

  typedef enum logic [2:0] {
    CM_OFF, CM_CAP, CM_TMR, CM_HSO, CM_FRQ, CM_PWMN, CM_PWM16
  } ccm_mode_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] val;
    logic [15:0] arl;
    logic        pin;
  } ccm_ch_t;

  function automatic ccm_mode_t ccm_dec(input logic [7:0] m);
    ccm_dec = CM_OFF;
    if (m[MB_CAPP:MB_CAPN] != 2'h0) begin
      if (m[MB_MAT:MB_PWM] == 3'h0) ccm_dec = CM_CAP;
    end else begin
      case (m[MB_MAT:MB_PWM])
        3'h4:       ccm_dec = CM_TMR;
        3'h6:       ccm_dec = CM_HSO;
        3'h3:       ccm_dec = CM_FRQ;
        3'h1, 3'h5: ccm_dec = m[MB_PWM16] ? CM_PWM16 : CM_PWMN;
        default:    ccm_dec = CM_OFF;
      endcase
    end
  endfunction : ccm_dec

  // low-bit mask of the shared 8..11 bit cycle
  function automatic logic [15:0] ccm_mask(input logic [1:0] cl);
    return (LEN_BASE << cl) - 16'h0001;
  endfunction : ccm_mask

endpackage : ccm_pkg

// file: src/ccm_edge.sv
`timescale 1ns/10ps
module ccm_edge #(
  parameter int W = 4
) (
  input  wire logic         i_clk,   // system clock
  input  wire logic         i_nrst,  // async reset, active low
  input  wire logic [W-1:0] i_pin,   // raw pin levels
  output logic      [W-1:0] o_rise,  // rising edge seen
  output logic      [W-1:0] o_fall   // falling edge seen
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ccm_edge_st_t;

  ccm_edge_st_t s;
  ccm_edge_st_t next_s;

  // s1 feeds s2 only; edges are taken between s2 and s3
  always_comb begin
    next_s    = s;
    next_s.s1 = i_pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) s <= '0;
    else s <= next_s;
  end

  assign o_rise = s.s2 & ~s.s3;
  assign o_fall = ~s.s2 & s.s3;
endmodule : ccm_edge

// file: src/ccm_irq.sv
`timescale 1ns/10ps
module ccm_irq #(
  parameter int W = 5
) (
  input  wire logic         i_clk,     // system clock
  input  wire logic         i_nrst,    // async reset, active low
  input  wire logic [W-1:0] i_set,     // event pulses
  input  wire logic [W-1:0] i_clr,     // software clear pulses
  input  wire logic [W-1:0] i_en,      // enables
  output logic      [W-1:0] o_status,  // sticky flags
  output logic              o_irq      // level interrupt
);
  typedef struct packed {
    logic [W-1:0] stat;
  } ccm_irq_st_t;

  ccm_irq_st_t s;
  ccm_irq_st_t next_s;

  // a set in the clearing cycle survives
  always_comb begin
    next_s      = s;
    next_s.stat = (s.stat & ~i_clr) | i_set;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) s <= '0;
    else s <= next_s;
  end

  assign o_status = s.stat;
  assign o_irq    = |(s.stat & i_en);
endmodule : ccm_irq

// file: src/ccm_top.sv
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/10ps
// How it works
// RULE1: every module picks one of six modes from its own mode register plus the shared pwm config.
// RULE2: all 8..11 bit pwm modules share the single cycle-length field.
// RULE3: with a module's flag interrupt enable set, its match/capture flag raises the interrupt.
// RULE4: mode bits 5:4 = 10 with 3:1 clear capture on a rising pin edge.
// RULE5: mode bits 5:4 = 01 with 3:1 clear capture on a falling pin edge.
// RULE6: mode bits 5:4 = 11 with 3:1 clear capture on either pin edge.
// RULE7: bit 3 alone is software timer, bits 3 and 2 high-speed output, bits 2 and 1 frequency output.
// RULE8: bit 7 clear, bit 1 set, bits 5,4,2 clear and cycle field 00 give 8-bit pwm.
// RULE9: the same mode with cycle field 01, 10, 11 gives 9, 10, 11 bit pwm.
// RULE10: bit 7 and bit 1 set with bits 5,4,2 clear give 16-bit pwm, ignoring cycle field and select.
// RULE11: comparator enable clear stops matches, freezes output pins and forces pwm output low.
// RULE12: in 9..11 bit pwm the select bit routes the value address to the auto-reload register.
// RULE13: with match flag enable set, a comparator match sets the match/capture flag.
// RULE14: pwm config bit 5 enables the interrupt on overflow of the current cycle length.
// RULE15: a qualifying capture edge copies the counter into the module value and sets its flag.
module ccm_top #(
  parameter int N = 4
) (
  input  wire logic         i_clk,              // system clock, 100 MHz
  input  wire logic         i_nrst,             // async reset, active low
  input  wire logic [7:0]   i_avs_address,      // byte address
  input  wire logic         i_avs_read,         // read request
  input  wire logic         i_avs_write,        // write request
  input  wire logic [31:0]  i_avs_writedata,    // write data
  output logic      [31:0]  o_avs_readdata,     // read data
  output logic              o_avs_waitrequest,  // stall
  input  wire logic [N-1:0] i_module_pin,       // pin levels in
  output logic      [N-1:0] o_module_pin,       // pin drive value
  output logic      [N-1:0] o_module_pin_oe_n,  // low while driving
  output logic              o_irq               // counter array interrupt
);
  localparam int W = N + 1;

  typedef struct packed {
    logic                     run;
    logic [15:0]              cnt;
    logic [7:0]               pwm;
    ccm_pkg::ccm_ch_t [N-1:0] ch;
    logic                     ack;
    logic [31:0]              rdata;
  } ccm_st_t;

  ccm_st_t            s;
  ccm_st_t            next_s;
  ccm_pkg::ccm_mode_t md [N];
  logic [15:0]        msk;
  logic               ovf;
  logic               req;
  logic               wr;
  logic [31:0]        rmux;
  logic [N-1:0]       rise;
  logic [N-1:0]       fall;
  logic [W-1:0]       ev;
  logic [W-1:0]       clr;
  logic [W-1:0]       en;
  logic [W-1:0]       stat;

  function automatic logic [7:0] ch_adr(input int i);
    return 8'(int'(ccm_pkg::A_CH_BASE) + ccm_pkg::CH_STRIDE * i);
  endfunction : ch_adr

  // value address steering, only live in 9..11 bit pwm
  function automatic logic use_arl(input ccm_pkg::ccm_mode_t m, input logic [7:0] p);
    return p[ccm_pkg::PB_ARSEL] && (m == ccm_pkg::CM_PWMN) && (p[1:0] != 2'h0);
  endfunction : use_arl

  ccm_edge #(
    .W(N)
  ) u_edge (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_pin  (i_module_pin),
    .o_rise (rise),
    .o_fall (fall)
  );

  ccm_irq #(
    .W(W)
  ) u_irq (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_set    (ev),
    .i_clr    (clr),
    .i_en     (en),
    .o_status (stat),
    .o_irq    (o_irq)
  );

  // one mask for every 8..11 bit module
  assign msk = ccm_pkg::ccm_mask(s.pwm[ccm_pkg::PB_CLSEL+:2]);  // RULE2 RULE8 RULE9
  assign ovf = s.run && ((s.cnt & msk) == msk);
  assign req = i_avs_read | i_avs_write;
  assign wr  = i_avs_write & s.ack;
  assign en[N] = s.pwm[ccm_pkg::PB_ECOV];  // RULE14

  for (genvar g = 0; g < N; g++) begin : g_ch
    assign md[g]    = ccm_pkg::ccm_dec(s.ch[g].mode);  // RULE1 RULE7
    assign en[g]    = s.ch[g].mode[ccm_pkg::MB_ECCF];  // RULE3
    assign o_module_pin[g] = s.ch[g].pin;
    assign o_module_pin_oe_n[g] = !(md[g] inside {ccm_pkg::CM_HSO, ccm_pkg::CM_FRQ,
                                                  ccm_pkg::CM_PWMN, ccm_pkg::CM_PWM16});
  end

  // one wait state: read data is registered before the answer
  assign o_avs_waitrequest = req & ~s.ack;
  assign o_avs_readdata    = s.rdata;

  always_comb begin
    rmux = 32'h0000_0000;
    case (i_avs_address)
      ccm_pkg::A_CTRL:   rmux = 32'(s.run);
      ccm_pkg::A_COUNT:  rmux = 32'(s.cnt);
      ccm_pkg::A_PWMCFG: rmux = 32'(s.pwm);
      ccm_pkg::A_STAT:   rmux = 32'(stat);
      ccm_pkg::A_IEN:    rmux = 32'(en);
      default:           rmux = 32'h0000_0000;
    endcase
    for (int i = 0; i < N; i++) begin
      if (i_avs_address == ch_adr(i)) rmux = 32'(s.ch[i].mode);
      if (i_avs_address == ch_adr(i) + ccm_pkg::A_VAL_OFS) begin
        rmux = 32'(use_arl(md[i], s.pwm) ? s.ch[i].arl : s.ch[i].val);  // RULE12
      end
    end
  end

  always_comb begin
    next_s     = s;
    ev         = '0;
    clr        = '0;
    next_s.ack = req & ~s.ack;
    if (req && !s.ack && i_avs_read) next_s.rdata = rmux;
    if (s.run) next_s.cnt = s.cnt + 16'h0001;
    ev[N] = ovf;  // RULE14

    // software writes first, so hardware updates below win a tie
    if (wr) begin
      case (i_avs_address)
        ccm_pkg::A_CTRL:   next_s.run = i_avs_writedata[0];
        ccm_pkg::A_COUNT:  next_s.cnt = i_avs_writedata[15:0];
        ccm_pkg::A_PWMCFG: next_s.pwm = i_avs_writedata[7:0];
        ccm_pkg::A_CLR:    clr = i_avs_writedata[W-1:0];
        ccm_pkg::A_IEN: begin
          next_s.pwm[ccm_pkg::PB_ECOV] = i_avs_writedata[N];
          for (int i = 0; i < N; i++) begin
            next_s.ch[i].mode[ccm_pkg::MB_ECCF] = i_avs_writedata[i];
          end
        end
        default: begin
          for (int i = 0; i < N; i++) begin
            if (i_avs_address == ch_adr(i)) next_s.ch[i].mode = i_avs_writedata[7:0];
            if (i_avs_address == ch_adr(i) + ccm_pkg::A_VAL_OFS) begin
              if (use_arl(md[i], s.pwm)) begin  // RULE12
                next_s.ch[i].arl = i_avs_writedata[15:0];
              end else begin
                next_s.ch[i].val = i_avs_writedata[15:0];
              end
            end
          end
        end
      endcase
    end

    for (int i = 0; i < N; i++) begin
      case (md[i])
        ccm_pkg::CM_CAP: begin
          if ((s.ch[i].mode[ccm_pkg::MB_CAPP] && rise[i]) ||  // RULE4 RULE6
              (s.ch[i].mode[ccm_pkg::MB_CAPN] && fall[i])) begin  // RULE5 RULE6
            next_s.ch[i].val = s.cnt;  // RULE15
            ev[i] = 1'h1;
          end
        end
        ccm_pkg::CM_TMR, ccm_pkg::CM_HSO: begin
          // comparator enable gates the match itself
          if (s.ch[i].mode[ccm_pkg::MB_ECOM] && s.run && s.cnt == s.ch[i].val) begin  // RULE11
            ev[i] = s.ch[i].mode[ccm_pkg::MB_MAT];  // RULE13
            if (md[i] == ccm_pkg::CM_HSO) next_s.ch[i].pin = ~s.ch[i].pin;
          end
        end
        ccm_pkg::CM_FRQ: begin
          if (s.ch[i].mode[ccm_pkg::MB_ECOM] && s.run && s.cnt[7:0] == s.ch[i].val[7:0]) begin  // RULE11
            next_s.ch[i].pin = ~s.ch[i].pin;
            next_s.ch[i].val[7:0] = s.ch[i].val[7:0] + s.ch[i].val[15:8];
          end
        end
        ccm_pkg::CM_PWMN: begin
          next_s.ch[i].pin = s.ch[i].mode[ccm_pkg::MB_ECOM] &&
                             ((s.cnt & msk) < (s.ch[i].val & msk));  // RULE11 RULE8 RULE9
          if (s.ch[i].mode[ccm_pkg::MB_ECOM] && s.run && (s.cnt & msk) == (s.ch[i].val & msk)) begin
            ev[i] = s.ch[i].mode[ccm_pkg::MB_MAT];  // RULE13
          end
          // auto-reload takes over at the cycle boundary in 9..11 bit
          if (ovf && s.pwm[1:0] != 2'h0) begin
            next_s.ch[i].val = (s.ch[i].val & ~msk) | (s.ch[i].arl & msk);
          end
        end
        ccm_pkg::CM_PWM16: begin
          next_s.ch[i].pin = s.ch[i].mode[ccm_pkg::MB_ECOM] && (s.cnt < s.ch[i].val);  // RULE10 RULE11
          if (s.ch[i].mode[ccm_pkg::MB_ECOM] && s.run && s.cnt == s.ch[i].val) begin
            ev[i] = s.ch[i].mode[ccm_pkg::MB_MAT];  // RULE13
          end
        end
        default: next_s.ch[i].pin = 1'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s     <= '0;
      s.pwm <= ccm_pkg::PWM_RST;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_cap_rise_copy: assert property (
    md[1] == ccm_pkg::CM_CAP && s.ch[1].mode[5:4] == 2'h2 && rise[1]
    |=> s.ch[1].val == $past(s.cnt) && stat[1]) else $error("rising capture missed");  // RULE4

  a_cap_fall_copy: assert property (
    md[1] == ccm_pkg::CM_CAP && s.ch[1].mode[5:4] == 2'h1 && fall[1]
    |=> s.ch[1].val == $past(s.cnt) && stat[1]) else $error("falling capture missed");  // RULE5

  a_cap_any_edge: assert property (
    md[1] == ccm_pkg::CM_CAP && s.ch[1].mode[5:4] == 2'h3 && (rise[1] || fall[1])
    |=> stat[1]) else $error("either-edge capture missed");  // RULE6

  // goes through the sticky flag, so a broken set path also fires here
  a_flag_irq_out: assert property (
    ev[1] && s.ch[1].mode[ccm_pkg::MB_ECCF] && !wr |=> o_irq) else $error("flag did not raise irq");  // RULE3

  a_pwm_off_low: assert property (
    (md[0] inside {ccm_pkg::CM_PWMN, ccm_pkg::CM_PWM16} && !s.ch[0].mode[ccm_pkg::MB_ECOM]) [*2]
    |-> !o_module_pin[0]) else $error("pwm output not low with comparator off");  // RULE11

  a_tmr_match_flag: assert property (
    md[2] == ccm_pkg::CM_TMR && s.ch[2].mode[ccm_pkg::MB_ECOM] && s.run && s.cnt == s.ch[2].val
    |=> stat[2]) else $error("timer match flag missing");  // RULE13

  a_hso_pin_toggle: assert property (
    md[2] == ccm_pkg::CM_HSO && s.ch[2].mode[ccm_pkg::MB_ECOM] && s.run && s.cnt == s.ch[2].val
    |=> o_module_pin[2] != $past(o_module_pin[2])) else $error("high-speed output did not toggle");  // RULE7

  a_ovf_ten_bit: assert property (
    s.run && s.pwm[1:0] == 2'h2 && s.cnt[9:0] == 10'h3ff
    |=> stat[N]) else $error("10-bit overflow flag missing");  // RULE14

  a_pwm16_duty_high: assert property (
    md[0] == ccm_pkg::CM_PWM16 && s.ch[0].mode[ccm_pkg::MB_ECOM] && s.cnt < s.ch[0].val
    |=> o_module_pin[0]) else $error("16-bit pwm not high below compare");  // RULE10

  a_bus_one_wait: assert property (
    req && !s.ack |=> !o_avs_waitrequest) else $error("bus answer late");

  c_capture_seen: cover property (md[1] == ccm_pkg::CM_CAP ##1 ev[1]);
  c_hso_toggle: cover property (md[2] == ccm_pkg::CM_HSO && ev[2]);
  c_irq_raised: cover property (!o_irq ##1 o_irq);
  c_pwm_reload: cover property (md[0] == ccm_pkg::CM_PWMN && ovf && s.pwm[1:0] != 2'h0);
endmodule : ccm_top

// file: verification/ccm_pin_model.sv
`timescale 1ns/10ps
module ccm_pin_model #(
  parameter int N = 4
) (
  input  wire logic [N-1:0] i_level,  // level the outside source wants
  input  wire logic [N-1:0] i_oe_n,   // design drive enable, low active
  input  wire logic [N-1:0] i_drv,    // design drive value
  output logic      [N-1:0] o_wire    // resolved pin level
);
  // the source steps back wherever the design drives, so no two drivers fight
  always_comb begin
    for (int i = 0; i < N; i++) begin
      o_wire[i] = i_oe_n[i] ? i_level[i] : i_drv[i];
    end
  end
endmodule : ccm_pin_model

// file: verification/tb_ccm_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_ccm_top;
  localparam int N = 4;
  logic         i_clk  = 1'b0;
  logic         i_nrst = 1'b0;
  logic [7:0]   adr    = 8'h00;
  logic         rd     = 1'b0;
  logic         wr     = 1'b0;
  logic [31:0]  wdat   = 32'h0000_0000;
  logic [N-1:0] lvl    = '0;
  logic [31:0]  rdat;
  logic         wreq;
  logic [N-1:0] pin_w;
  logic [N-1:0] pin_o;
  logic [N-1:0] oe_n;
  logic         irq;
  logic [31:0]  q;
  logic [15:0]  c;
  logic [15:0]  v;
  logic [7:0]   m;
  logic [1:0]   cl;
  logic         p;
  int           errors      = 0;
  int           check_count = 0;
  logic [7:0]   cap_md [3] = '{8'h21, 8'h11, 8'h30};
  logic [7:0]   cmp_md [5] = '{8'h49, 8'h09, 8'h4D, 8'h0D, 8'h46};
  logic [7:0]   pwm_md [3] = '{8'h42, 8'hC2, 8'h02};

  always #5 i_clk = ~i_clk;

  ccm_top #(.N(N)) u_ccm_top (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_module_pin(pin_w), .o_module_pin(pin_o), .o_module_pin_oe_n(oe_n), .o_irq(irq)
  );
  ccm_pin_model #(.N(N)) u_ccm_pin_model (.i_level(lvl), .i_oe_n(oe_n), .i_drv(pin_o), .o_wire(pin_w));

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    // waitrequest and read data are taken at the rising edge, before that edge's updates land
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (wreq === 1'b0) break;
    end
    if (k == 20) begin
      errors++;
      give_verdict();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, q)
  endtask : rchk

  // ends off the rising edge so flop updates have landed before a look
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : tick

  function automatic logic pwm_exp(input logic [7:0] md, input logic [1:0] l, input logic [15:0] cn,
                                   input logic [15:0] vl);
    logic [15:0] mk;
    mk = (16'h0100 << l) - 16'h0001;
    if (!md[6]) return 1'b0;
    if (md[7]) return cn < vl;
    return (cn & mk) < (vl & mk);
  endfunction : pwm_exp

  initial begin
    void'($urandom(32'h4156));
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    tick(1);
    `CHK("irq at reset", 1'b0, irq)
    rchk(ccm_pkg::A_PWMCFG, 32'(ccm_pkg::PWM_RST), "pwm cfg reset");
    rchk(ccm_pkg::A_STAT, 32'h0000_0000, "status reset");
    rchk(8'hFC, 32'h0000_0000, "unmapped");
    m = 8'($urandom);
    wreg(8'h20, 32'(m));
    rchk(8'h20, 32'(m), "mode reg");
    // capture on module 1; the counter stays stopped so the captured value is known
    foreach (cap_md[j]) begin
      m = cap_md[j];
      lvl[1] <= 1'b1;
      wreg(8'h28, 32'h0000_0000);
      tick(6);
      wreg(ccm_pkg::A_CLR, 32'h0000_001F);
      wreg(8'h28, 32'(m));
      c = 16'($urandom);
      wreg(ccm_pkg::A_COUNT, 32'(c));
      lvl[1] <= 1'b0;
      tick(8);
      `CHK("capture irq", m[4] & m[0], irq)
      rchk(ccm_pkg::A_STAT, 32'(m[4]) << 1, "fall capture");
      wreg(ccm_pkg::A_CLR, 32'h0000_001F);
      c = 16'($urandom);
      wreg(ccm_pkg::A_COUNT, 32'(c));
      lvl[1] <= 1'b1;
      tick(8);
      rchk(ccm_pkg::A_STAT, 32'(m[5]) << 1, "rise capture");
      if (m[5]) rchk(8'h2C, 32'(c), "capture value");
    end
    // compare modes on module 2: one match as the counter runs past the value
    foreach (cmp_md[j]) begin
      m = cmp_md[j];
      wreg(ccm_pkg::A_CLR, 32'h0000_001F);
      wreg(8'h30, 32'(m));
      wreg(ccm_pkg::A_COUNT, 32'h0000_0010);
      wreg(8'h34, 32'h0000_0014);
      p = pin_o[2];
      wreg(ccm_pkg::A_CTRL, 32'h0000_0001);
      tick(10);
      wreg(ccm_pkg::A_CTRL, 32'h0000_0000);
      tick(1);
      `CHK("match irq", m[0] & m[3] & m[6], irq)
      `CHK("pin toggle", p ^ (m[2] & m[6]), pin_o[2])
      `CHK("drive enable", ~m[2], oe_n[2])
      rchk(ccm_pkg::A_STAT, 32'(m[6] & m[3]) << 2, "match flag");
    end
    // pwm level on module 0 with the counter frozen; first rounds sit where the mask matters
    for (int k = 0; k < 12; k++) begin
      m  = pwm_md[k % 3];
      cl = 2'(k);
      c  = (k < 4) ? 16'h0080 : 16'($urandom);
      v  = (k < 4) ? 16'h0180 : 16'($urandom);
      wreg(ccm_pkg::A_PWMCFG, 32'(cl));
      wreg(8'h20, 32'(m));
      wreg(8'h24, 32'(v));
      wreg(ccm_pkg::A_COUNT, 32'(c));
      tick(3);
      `CHK("pwm level", pwm_exp(m, cl, c, v), pin_o[0])
    end
    // value address steering on module 3
    wreg(8'h38, 32'h0000_0042);
    wreg(ccm_pkg::A_PWMCFG, 32'h0000_0001);
    wreg(8'h3C, 32'h0000_1234);
    wreg(ccm_pkg::A_PWMCFG, 32'h0000_0081);
    wreg(8'h3C, 32'h0000_00AB);
    rchk(8'h3C, 32'h0000_00AB, "reload reg");
    wreg(8'h38, 32'h0000_00C2);
    rchk(8'h3C, 32'h0000_1234, "pwm16 value");
    wreg(8'h38, 32'h0000_0042);
    wreg(ccm_pkg::A_PWMCFG, 32'h0000_0001);
    rchk(8'h3C, 32'h0000_1234, "compare reg");
    // overflow of the 10-bit cycle
    wreg(ccm_pkg::A_CLR, 32'h0000_001F);
    wreg(ccm_pkg::A_PWMCFG, 32'h0000_0022);
    wreg(ccm_pkg::A_COUNT, 32'h0000_03F8);
    wreg(ccm_pkg::A_CTRL, 32'h0000_0001);
    tick(12);
    wreg(ccm_pkg::A_CTRL, 32'h0000_0000);
    rchk(ccm_pkg::A_STAT, 32'h0000_0010, "overflow flag");
    tick(1);
    `CHK("overflow irq", 1'b1, irq)
    wreg(ccm_pkg::A_CLR, 32'h0000_0010);
    tick(1);
    `CHK("irq cleared", 1'b0, irq)
    give_verdict();
  end
endmodule : tb_ccm_top
